// *** src/pcr_pkg.sv ***
// pcr_pkg: offsets, field positions and reset values of the pll control register bank
// assumes byte-wide registers reached through a two-wire serial configuration port
// Behaviour
// - bit 0 of register 0x17 bypasses the first-stage loop when 1 and lets it run when 0.
// - bit 0 of register 0x18 bypasses the synthesizer loop when 1, sending first-stage output to the dividers.
// - bit 7 of register 0x1C selects oscillator polarity, 0 positive and 1 negative, resetting to 0.
// - bit 6 of register 0x1C at 1 forces the loop filter control pin to mid-supply, 0 is normal.
// - the force-mid-voltage bit comes out of reset at 1 so the oscillator starts centred.
// - bits 4:0 of register 0x1C hold the first-stage pump code, current (code+1)*50uA, reset 01111.
// - bits 4:0 of register 0x1E hold the second-stage pump code, current (code+1)*200uA.
// - bit 5 of register 0x1D enables the static phase offset on the first-stage detector.
// - bits 4:0 of register 0x1D hold the phase offset code in 0.9 degree steps, resetting to zero.
package pcr_pkg;
  localparam logic [7:0] ADDR_FIRST_LOOP_BYPASS_CTRL = 8'h17;
  localparam logic [7:0] ADDR_SYNTH_LOOP_BYPASS_CTRL = 8'h18;
  localparam logic [7:0] ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL = 8'h1D;
  localparam logic [7:0] ADDR_SECOND_LOOP_PUMP_CTRL = 8'h1E;
  localparam int BYPASS_BIT = 0;
  localparam int POLARITY_BIT = 7;
  localparam int FORCE_MID_BIT = 6;
  localparam int OFFSET_ENABLE_BIT = 5;
  localparam int CODE_MSB = 4;
  localparam logic RST_FIRST_LOOP_BYPASS = 1'h0;
  localparam logic RST_SYNTH_LOOP_BYPASS = 1'h0;
  localparam logic RST_OSCILLATOR_POLARITY = 1'h0;
  localparam logic RST_FORCE_MID = 1'h1;
  localparam logic [4:0] RST_FIRST_LOOP_PUMP = 5'h0F;
  localparam logic RST_OFFSET_ENABLE = 1'h0;
  localparam logic [4:0] RST_PHASE_OFFSET = 5'h00;
  localparam logic [4:0] RST_SECOND_LOOP_PUMP = 5'h18;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [6:0] {
    PCR_IDLE    = 7'h01,
    PCR_ADDR    = 7'h02,
    PCR_PTR     = 7'h04,
    PCR_WR      = 7'h08,
    PCR_ACK_OUT = 7'h10,
    PCR_RD      = 7'h20,
    PCR_ACK_IN  = 7'h40
  } pcr_state_t;
endpackage

// *** src/pcr_pll_control_regs.sv ***
// pcr_pll_control_regs: serial configuration slave and the five pll control registers
// assumes scl and sda already synchronous to MCLK and much slower than it; sda is open drain
`timescale 1ns/100ps
module pcr_pll_control_regs import pcr_pkg::*; #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h54, // arbitrary value
  parameter logic [4:0] SECOND_PUMP_RESET = RST_SECOND_LOOP_PUMP
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic FIRST_LOOP_BYPASS,
  output logic SYNTH_LOOP_BYPASS,
  output logic OSCILLATOR_POLARITY,
  output logic FORCE_MID_CONTROL_VOLTAGE,
  output logic [4:0] FIRST_LOOP_PUMP_CURRENT,
  output logic PHASE_OFFSET_ENABLE,
  output logic [4:0] PHASE_OFFSET,
  output logic [4:0] SECOND_LOOP_PUMP_CURRENT
);
  logic scl_q, sda_q, scl_d, sda_d;
  pcr_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shift, next_shift, ptr, next_ptr;
  logic ptr_done, next_ptr_done, reading, next_reading, next_sda_oe, wr_en;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic next_byp1, next_byp2, next_pol, next_fmid, next_oen;
  logic [4:0] next_cpv, next_offs, next_cpf;

  // reserved positions are zero-filled on read
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      ADDR_FIRST_LOOP_BYPASS_CTRL: reg_read = {7'h00, FIRST_LOOP_BYPASS};
      ADDR_SYNTH_LOOP_BYPASS_CTRL: reg_read = {7'h00, SYNTH_LOOP_BYPASS};
      ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL:
        reg_read = {OSCILLATOR_POLARITY, FORCE_MID_CONTROL_VOLTAGE, 1'h0, FIRST_LOOP_PUMP_CURRENT};
      ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL: reg_read = {2'h0, PHASE_OFFSET_ENABLE, PHASE_OFFSET};
      ADDR_SECOND_LOOP_PUMP_CTRL: reg_read = {3'h0, SECOND_LOOP_PUMP_CURRENT};
      default: reg_read = BYTE_ZERO;
    endcase
  endfunction

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_q <= SCL_IN;
      sda_q <= SDA_IN;
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign start_seen = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_seen = scl_q & scl_d & ~sda_d & sda_q;

  // serial slave: pointer byte then auto-incrementing data, reads from the same pointer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_ptr_done = ptr_done;
    next_reading = reading;
    next_sda_oe = SDA_OE;
    wr_en = 1'h0;
    if (start_seen) begin
      next_state = PCR_ADDR;
      next_cnt = 4'h0;
      next_ptr_done = 1'h0;
      next_sda_oe = 1'h0;
    end else if (stop_seen) begin
      next_state = PCR_IDLE;
      next_sda_oe = 1'h0;
    end else begin
      unique case (state)
        PCR_IDLE: begin
          next_sda_oe = 1'h0;
        end
        PCR_ADDR, PCR_PTR, PCR_WR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_q};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BITS_PER_BYTE) begin
            next_cnt = 4'h0;
            next_state = PCR_ACK_OUT;
            next_sda_oe = 1'h1;
            if (state == PCR_ADDR) begin
              next_reading = shift[0];
              if (shift[7:1] != DEVICE_ADDRESS) begin
                next_state = PCR_IDLE;
                next_sda_oe = 1'h0;
              end
            end else if (state == PCR_PTR) begin
              next_ptr = shift;
              next_ptr_done = 1'h1;
            end else begin
              wr_en = 1'h1;
              next_ptr = ptr + 8'h01;
            end
          end
        end
        PCR_ACK_OUT: begin
          if (scl_fall) begin
            if (reading) begin
              next_state = PCR_RD;
              next_shift = reg_read(ptr);
              next_sda_oe = ~next_shift[7];
            end else begin
              next_state = ptr_done ? PCR_WR : PCR_PTR;
              next_sda_oe = 1'h0;
            end
          end
        end
        PCR_RD: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_cnt = 4'h0;
              next_state = PCR_ACK_IN;
              next_sda_oe = 1'h0;
              next_ptr = ptr + 8'h01;
            end else begin
              next_shift = {shift[6:0], 1'h0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        PCR_ACK_IN: begin
          // a master nack ends the read; we stay off the line until the next start
          if (scl_rise && sda_q) begin
            next_state = PCR_IDLE;
          end else if (scl_fall) begin
            next_state = PCR_RD;
            next_shift = reg_read(ptr);
            next_sda_oe = ~next_shift[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= PCR_IDLE;
      cnt <= 4'h0;
      shift <= BYTE_ZERO;
      ptr <= BYTE_ZERO;
      ptr_done <= 1'h0;
      reading <= 1'h0;
      SDA_OE <= 1'h0;
      SDA_OUT <= 1'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      ptr_done <= next_ptr_done;
      reading <= next_reading;
      SDA_OE <= next_sda_oe;
      SDA_OUT <= 1'h0;
    end
  end

  // register writes land on the ack-entry edge; reserved bits are dropped
  always_comb begin
    next_byp1 = FIRST_LOOP_BYPASS;
    next_byp2 = SYNTH_LOOP_BYPASS;
    next_pol = OSCILLATOR_POLARITY;
    next_fmid = FORCE_MID_CONTROL_VOLTAGE;
    next_cpv = FIRST_LOOP_PUMP_CURRENT;
    next_oen = PHASE_OFFSET_ENABLE;
    next_offs = PHASE_OFFSET;
    next_cpf = SECOND_LOOP_PUMP_CURRENT;
    if (wr_en) begin
      unique case (ptr)
        ADDR_FIRST_LOOP_BYPASS_CTRL: next_byp1 = shift[BYPASS_BIT];
        ADDR_SYNTH_LOOP_BYPASS_CTRL: next_byp2 = shift[BYPASS_BIT];
        ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL: begin
          next_pol = shift[POLARITY_BIT];
          next_fmid = shift[FORCE_MID_BIT];
          next_cpv = shift[CODE_MSB:0];
        end
        ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL: begin
          next_oen = shift[OFFSET_ENABLE_BIT];
          next_offs = shift[CODE_MSB:0];
        end
        ADDR_SECOND_LOOP_PUMP_CTRL: next_cpf = shift[CODE_MSB:0];
        default: next_byp1 = FIRST_LOOP_BYPASS;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FIRST_LOOP_BYPASS <= RST_FIRST_LOOP_BYPASS;
      SYNTH_LOOP_BYPASS <= RST_SYNTH_LOOP_BYPASS;
      OSCILLATOR_POLARITY <= RST_OSCILLATOR_POLARITY;
      FORCE_MID_CONTROL_VOLTAGE <= RST_FORCE_MID;
      FIRST_LOOP_PUMP_CURRENT <= RST_FIRST_LOOP_PUMP;
      PHASE_OFFSET_ENABLE <= RST_OFFSET_ENABLE;
      PHASE_OFFSET <= RST_PHASE_OFFSET;
      SECOND_LOOP_PUMP_CURRENT <= SECOND_PUMP_RESET;
    end else begin
      FIRST_LOOP_BYPASS <= next_byp1;
      SYNTH_LOOP_BYPASS <= next_byp2;
      OSCILLATOR_POLARITY <= next_pol;
      FORCE_MID_CONTROL_VOLTAGE <= next_fmid;
      FIRST_LOOP_PUMP_CURRENT <= next_cpv;
      PHASE_OFFSET_ENABLE <= next_oen;
      PHASE_OFFSET <= next_offs;
      SECOND_LOOP_PUMP_CURRENT <= next_cpf;
    end
  end

  // helper: no write has reached 0x1C since reset
  logic pump_reg_untouched;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pump_reg_untouched <= 1'h1;
    end else if (wr_en && ptr == ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL) begin
      pump_reg_untouched <= 1'h0;
    end
  end

  property p_first_bypass;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_en && ptr == ADDR_FIRST_LOOP_BYPASS_CTRL |=> FIRST_LOOP_BYPASS == $past(shift[0]);
  endproperty
  a_first_bypass: assert property (p_first_bypass) else $error("first loop bypass not written");
  property p_synth_bypass;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_en && ptr == ADDR_SYNTH_LOOP_BYPASS_CTRL |=> SYNTH_LOOP_BYPASS == $past(shift[0]);
  endproperty
  a_synth_bypass: assert property (p_synth_bypass) else $error("synth loop bypass not written");
  property p_polarity;
    @(posedge MCLK) disable iff (!RESET_N)
      pump_reg_untouched |-> !OSCILLATOR_POLARITY;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity left its reset value");
  property p_force_mid;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_en && ptr == ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL |=> FORCE_MID_CONTROL_VOLTAGE == $past(shift[6]);
  endproperty
  a_force_mid: assert property (p_force_mid) else $error("force mid bit not written");
  property p_force_mid_reset;
    @(posedge MCLK) disable iff (!RESET_N)
      pump_reg_untouched |-> FORCE_MID_CONTROL_VOLTAGE && FIRST_LOOP_PUMP_CURRENT == RST_FIRST_LOOP_PUMP;
  endproperty
  a_force_mid_reset: assert property (p_force_mid_reset) else $error("startup value of 0x1C lost");
  property p_first_pump;
    @(posedge MCLK) disable iff (!RESET_N)
      !(wr_en && ptr == ADDR_FIRST_LOOP_PUMP_POLARITY_CTRL) |=> $stable(FIRST_LOOP_PUMP_CURRENT);
  endproperty
  a_first_pump: assert property (p_first_pump) else $error("pump code changed without a write");
  property p_second_pump;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_en && ptr == ADDR_SECOND_LOOP_PUMP_CTRL |=> SECOND_LOOP_PUMP_CURRENT == $past(shift[4:0]);
  endproperty
  a_second_pump: assert property (p_second_pump) else $error("second pump code not written");
  property p_offset;
    @(posedge MCLK) disable iff (!RESET_N)
      wr_en && ptr == ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL
        |=> PHASE_OFFSET_ENABLE == $past(shift[5]) && PHASE_OFFSET == $past(shift[4:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("phase offset not written");
  property p_offset_hold;
    @(posedge MCLK) disable iff (!RESET_N)
      !(wr_en && ptr == ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL) |=> $stable(PHASE_OFFSET);
  endproperty
  a_offset_hold: assert property (p_offset_hold) else $error("offset changed without a write");
  property p_reserved;
    @(posedge MCLK) disable iff (!RESET_N)
      state == PCR_ACK_OUT && scl_fall && reading && ptr == ADDR_SECOND_LOOP_PUMP_CTRL
        |=> shift[7:5] == 3'h0 && SDA_OE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
endmodule // pcr_pll_control_regs

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for the pll control register bank, host side bit-banged here
// assumes the data wire has a pull-up, so a released wire reads high
`timescale 1ns/100ps
module tb_top import pcr_pkg::*;;
  localparam logic [6:0] DEV = 7'h54; // arbitrary value
  typedef struct packed {logic [7:0] ptr; logic [7:0] wd; logic [7:0] rd;} pcr_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic scl = 1'b1;
  logic sda_h = 1'b1;
  logic sda_oe, sda_out, flb, slb, pol, fmv, poe;
  logic [4:0] fpc, po, spc;
  wire logic sda_w;
  wire logic [19:0] outs;
  logic [7:0] img [5];
  logic [7:0] ptrs [5] = '{8'h17, 8'h18, 8'h1C, 8'h1D, 8'h1E};
  logic ack;
  logic [7:0] d;
  int fails = 0;
  int checked = 0;
  // reserved bits drop out of the expected readback column
  pcr_row_t rows [13] = '{'{8'h17, 8'hFF, 8'h01}, '{8'h18, 8'hFE, 8'h00}, '{8'h18, 8'hFF, 8'h01},
    '{8'h1C, 8'hFF, 8'hDF}, '{8'h1C, 8'h20, 8'h00}, '{8'h1D, 8'hFF, 8'h3F}, '{8'h1D, 8'h1F, 8'h1F},
    '{8'h1E, 8'hFF, 8'h1F}, '{8'h1E, 8'h00, 8'h00}, '{8'h17, 8'h00, 8'h00}, '{8'h1C, 8'h9E, 8'h9E},
    '{8'h1D, 8'h20, 8'h20}, '{8'h1E, 8'hE6, 8'h06}};

  // device only ever pulls low
  assign sda_w = (sda_oe & ~sda_out) ? 1'b0 : sda_h;
  assign outs = {flb, slb, pol, fmv, fpc, poe, po, spc};

  always #20 mclk = ~mclk;

  pcr_pll_control_regs #(.DEVICE_ADDRESS(DEV)) uut (
    .MCLK(mclk),
    .RESET_N(reset_n),
    .SCL_IN(scl),
    .SDA_IN(sda_w),
    .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .FIRST_LOOP_BYPASS(flb),
    .SYNTH_LOOP_BYPASS(slb),
    .OSCILLATOR_POLARITY(pol),
    .FORCE_MID_CONTROL_VOLTAGE(fmv),
    .FIRST_LOOP_PUMP_CURRENT(fpc),
    .PHASE_OFFSET_ENABLE(poe),
    .PHASE_OFFSET(po),
    .SECOND_LOOP_PUMP_CURRENT(spc)
  );

  function automatic logic [19:0] exp_outs();
    return {img[0][0], img[1][0], img[2][7:6], img[2][4:0], img[3][5:0], img[4][4:0]};
  endfunction

  function automatic int idx(input logic [7:0] p);
    return (p == 8'h17) ? 0 : (p == 8'h18) ? 1 : int'(p) - 26;
  endfunction

  task automatic reset_image();
    img = '{8'h00, 8'h00, 8'h4F, 8'h00, 8'h18};
  endtask

  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // each phase lasts 6 MCLK, above the 2 the slave needs; data bits move only while clock is low, start and stop move data while clock is high
  task automatic drv(input logic c, input logic s);
    scl <= c;
    sda_h <= s;
    repeat (6) @(posedge mclk);
  endtask

  task automatic start_c();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask

  task automatic stop_c();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      drv(1'b0, b[i]);
      drv(1'b1, b[i]);
      drv(1'b0, b[i]);
    end
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    a = ~sda_w;
    drv(1'b0, 1'b1);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      b[i] = sda_w;
      drv(1'b0, 1'b1);
    end
    drv(1'b0, nack);
    drv(1'b1, nack);
    drv(1'b0, nack);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [2:0] a;
    start_c();
    wbyte({DEV, 1'b0}, a[2]);
    wbyte(p, a[1]);
    wbyte(v, a[0]);
    stop_c();
    chk("write ack", 20'(a), 20'h7);
  endtask

  task automatic rd_start(input logic [7:0] p);
    start_c();
    wbyte({DEV, 1'b0}, ack);
    wbyte(p, ack);
    start_c();
    wbyte({DEV, 1'b1}, ack);
  endtask

  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    rd_start(p);
    rbyte(1'b1, v);
    stop_c();
  endtask

  task automatic check_reset_state();
    reset_image();
    chk("reset outputs", outs, exp_outs());
    chk("reset sda_oe", 20'(sda_oe), 20'h0);
    chk("reset sda drive level", 20'(sda_out), 20'h0);
    for (int k = 0; k < 5; k++) begin
      rd(ptrs[k], d);
      chk("reset readback", 20'(d), 20'(img[k]));
    end
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check_reset_state();
    foreach (rows[k]) begin
      wr(rows[k].ptr, rows[k].wd);
      rd(rows[k].ptr, d);
      chk("readback", 20'(d), 20'(rows[k].rd));
      img[idx(rows[k].ptr)] = rows[k].rd;
      chk("outputs", outs, exp_outs());
    end
    // burst write across three registers relies on pointer auto-increment
    start_c();
    wbyte({DEV, 1'b0}, ack);
    wbyte(8'h1C, ack);
    wbyte(8'h83, ack);
    wbyte(8'h3A, ack);
    wbyte(8'hFF, ack);
    stop_c();
    img[2] = 8'h83;
    img[3] = 8'h3A;
    img[4] = 8'h1F;
    chk("burst outputs", outs, exp_outs());
    rd_start(8'h1C);
    for (int k = 2; k < 5; k++) begin
      rbyte(k == 4, d);
      chk("burst readback", 20'(d), 20'(img[k]));
    end
    stop_c();
    // host parks the offset at zero once it no longer needs it
    wr(ADDR_FIRST_LOOP_PHASE_OFFSET_CTRL, 8'h00);
    img[3] = BYTE_ZERO;
    chk("offset parked", outs, exp_outs());
    // a frame for another address is neither acknowledged nor applied
    start_c();
    wbyte({DEV ^ 7'h01, 1'b0}, ack);
    chk("foreign address ack", 20'(ack), 20'h0);
    wbyte(8'h17, ack);
    wbyte(8'h01, ack);
    stop_c();
    chk("foreign address outputs", outs, exp_outs());
    // an unmapped pointer takes the write, changes nothing and reads zero
    wr(8'h19, 8'hFF);
    chk("unmapped outputs", outs, exp_outs());
    rd(8'h19, d);
    chk("unmapped readback", 20'(d), 20'h0);
    // second reset in mid-run must bring back the startup image
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_image();
    chk("outputs in reset", outs, exp_outs());
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check_reset_state();
    print_verdict();
  end
endmodule // tb_top
